// [hdl/adcfg_ctrl.sv]
// What this block does
// - writing one to the trigger bit while idle starts exactly one conversion
// - trigger writes are taken only while idle, ignored during a conversion
// - trigger bit reads zero while converting and one otherwise
// - input select field routes the analog inputs, resets to code zero
// - gain field picks the full scale range, resets to code two
// - mode bit picks continuous or one-shot conversions, resets to one-shot
// - rate field picks the sample rate, resets to code four
// - comparator style bit picks traditional or window comparison
// - polarity bit makes the flag output active low or active high
// - without latching the flag releases on an in-window result in window mode, or a result below the low threshold in traditional mode
// - with latching the flag holds until a result read or alert response
// - queue code three disables comparator and floats the flag output
// - flag asserts after one, two or four consecutive out-of-range results
// - configuration sits at pointer one and resets to 8583h
// - register bytes travel most significant byte first, then least
// - ready mode mirrors trigger bit in one-shot, pulses per continuous result
module adcfg_ctrl (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic link_clk,
    input wire adcfg_pkg::adcfg_byte_t lnk_wr,
    input wire logic lnk_rd_req,
    input wire logic lnk_rd_msb,
    input wire logic [1:0] lnk_rd_ptr,
    input wire logic lnk_conv_read,
    input wire logic lnk_alert_resp,
    output logic [7:0] lnk_rd_data,
    output logic lnk_alert_pending,
    input wire logic conv_done,
    input wire logic [15:0] conv_result,
    input wire logic [15:0] lo_thresh,
    input wire logic [15:0] hi_thresh,
    output logic conv_start,
    output logic [2:0] input_select,
    output logic [2:0] gain_range_select,
    output logic [2:0] sample_rate_select,
    output logic cont_mode,
    output logic alert_out,
    output logic alert_oe_n
);
    import adcfg_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] queue_need(input logic [1:0] q);
        case (q)
            ADCFG_QUE_ONE: queue_need = ADCFG_NEED_1;
            ADCFG_QUE_TWO: queue_need = ADCFG_NEED_2;
            default: queue_need = ADCFG_NEED_4;
        endcase
    endfunction : queue_need

    function automatic logic [2:0] gain_map(input logic [2:0] g);
        gain_map = (g == ADCFG_GAIN_UNDOC) ? ADCFG_GAIN_MIN : g;
    endfunction : gain_map

    adcfg_core_t r_reg;
    adcfg_core_t r_next;
    adcfg_link_t l_reg;
    adcfg_link_t l_next;
    logic [1:0] lrst_reg;
    logic link_rst;

    // ------------------------------------------------------------
    // link domain
    // ------------------------------------------------------------
    assign link_rst = lrst_reg[1];

    always_ff @(posedge link_clk) begin
        lrst_reg <= {lrst_reg[0], sys_rst};
    end

    always_comb begin
        l_next = l_reg;
        l_next.rb_sync = {l_reg.rb_sync[1:0], r_reg.rb_tgl};
        l_next.alert_sync = {l_reg.alert_sync[0], r_reg.alert_act};
        // alert response arbitration is left to the serial engine
        l_next.alert_pending = l_reg.alert_sync[1];
        if (l_reg.rb_sync[2] != l_reg.rb_sync[1]) begin
            l_next.rb_copy = r_reg.rb_word;
            l_next.ack_tgl = l_reg.rb_sync[1];
        end
        if (lnk_wr.valid && lnk_wr.ptr == ADCFG_PTR_CONFIG) begin
            if (lnk_wr.msb) begin
                l_next.msb_hold = lnk_wr.data;
                l_next.have_msb = 1'b1;
            end else if (l_reg.have_msb) begin
                l_next.wr_word = {l_reg.msb_hold, lnk_wr.data};
                l_next.wr_tgl = ~l_reg.wr_tgl;
                l_next.have_msb = 1'b0;
            end
        end
        if (lnk_rd_req) begin
            if (lnk_rd_ptr != ADCFG_PTR_CONFIG) begin
                l_next.rd_data = 8'h00;
            end else if (lnk_rd_msb) begin
                l_next.rd_data = l_reg.rb_copy[15:8];
            end else begin
                l_next.rd_data = l_reg.rb_copy[7:0];
            end
        end
        if (lnk_conv_read) begin
            l_next.rd_tgl = ~l_reg.rd_tgl;
        end
        if (lnk_alert_resp) begin
            l_next.ara_tgl = ~l_reg.ara_tgl;
        end
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            l_reg <= '0;
            l_reg.rb_copy <= ADCFG_CFG_RESET;
        end else begin
            l_reg <= l_next;
        end
    end

    // ------------------------------------------------------------
    // core domain
    // ------------------------------------------------------------
    logic wr_evt;
    logic clr_evt;
    logic comp_en;
    logic rdy_mode;
    logic beyond_hi;
    logic below_lo;
    logic trip;
    logic flag_act;
    logic [15:0] cur_word;

    // the link word is stable long before its toggle arrives here
    assign wr_evt = r_reg.wr_sync[1] ^ r_reg.wr_sync[2];
    assign clr_evt = (r_reg.rd_sync[1] ^ r_reg.rd_sync[2])
        | (r_reg.ara_sync[1] ^ r_reg.ara_sync[2]);
    assign comp_en = r_reg.cfg[ADCFG_QUE_LSB +: 2] != ADCFG_QUE_OFF;
    assign rdy_mode = hi_thresh[ADCFG_THR_MSB] && !lo_thresh[ADCFG_THR_MSB];
    assign beyond_hi = $signed(conv_result) > $signed(hi_thresh);
    assign below_lo = $signed(conv_result) < $signed(lo_thresh);
    assign trip = r_reg.cfg[ADCFG_CMODE_BIT] ? (beyond_hi | below_lo) : beyond_hi;

    always_comb begin
        r_next = r_reg;
        flag_act = 1'b0;
        cur_word = '0;
        r_next.conv_start = 1'b0;
        r_next.rdy_pulse = 1'b0;
        r_next.wr_sync = {r_reg.wr_sync[1:0], l_reg.wr_tgl};
        r_next.rd_sync = {r_reg.rd_sync[1:0], l_reg.rd_tgl};
        r_next.ara_sync = {r_reg.ara_sync[1:0], l_reg.ara_tgl};
        r_next.ack_sync = {r_reg.ack_sync[0], l_reg.ack_tgl};
        if (wr_evt) begin
            r_next.cfg[14:0] = l_reg.wr_word[14:0];
        end
        case (r_reg.state)
            ADCFG_IDLE: begin
                if (!r_next.cfg[ADCFG_MODE_BIT]) begin
                    r_next.conv_start = 1'b1;
                    r_next.state = ADCFG_BUSY;
                end else if (wr_evt && l_reg.wr_word[ADCFG_TRIG_BIT]) begin
                    r_next.conv_start = 1'b1;
                    r_next.state = ADCFG_BUSY;
                end
            end
            ADCFG_BUSY: begin
                // trigger writes fall through here unused
                if (conv_done) begin
                    r_next.rdy_pulse = 1'b1;
                    if (!r_next.cfg[ADCFG_MODE_BIT]) begin
                        r_next.conv_start = 1'b1;
                    end else begin
                        r_next.state = ADCFG_IDLE;
                    end
                end
            end
            default: begin
                r_next.state = ADCFG_IDLE;
            end
        endcase
        // comparator: clear first so that a new trip in the same cycle wins
        if (!comp_en) begin
            r_next.alert_act = 1'b0;
            r_next.run_cnt = '0;
        end else begin
            if (clr_evt && r_reg.cfg[ADCFG_LAT_BIT]) begin
                r_next.alert_act = 1'b0;
            end
            if (conv_done && r_reg.state == ADCFG_BUSY) begin
                if (trip) begin
                    if (r_reg.run_cnt < ADCFG_NEED_4) begin
                        r_next.run_cnt = r_reg.run_cnt + 3'h1;
                    end
                    if (r_reg.run_cnt + 3'h1 >= queue_need(r_reg.cfg[ADCFG_QUE_LSB +: 2])) begin
                        r_next.alert_act = 1'b1;
                    end
                end else begin
                    r_next.run_cnt = '0;
                    if (!r_reg.cfg[ADCFG_LAT_BIT]) begin
                        if (r_reg.cfg[ADCFG_CMODE_BIT] || below_lo) begin
                            r_next.alert_act = 1'b0;
                        end
                    end else if (!clr_evt) begin
                        r_next.alert_act = r_reg.alert_act;
                    end
                end
            end
        end
        cur_word = {r_next.state == ADCFG_IDLE, r_next.cfg[14:0]};
        if (rdy_mode) begin
            flag_act = r_next.cfg[ADCFG_MODE_BIT] ? cur_word[ADCFG_TRIG_BIT]
                : r_next.rdy_pulse;
        end else begin
            flag_act = r_next.alert_act;
        end
        r_next.alert_pin = r_next.cfg[ADCFG_POL_BIT] ? flag_act : ~flag_act;
        r_next.alert_oe_n = r_next.cfg[ADCFG_QUE_LSB +: 2] == ADCFG_QUE_OFF;
        r_next.gain_eff = gain_map(r_next.cfg[ADCFG_GAIN_LSB +: 3]);
        if (r_reg.rb_tgl == r_reg.ack_sync[1] && r_reg.rb_word != cur_word) begin
            r_next.rb_word = cur_word;
            r_next.rb_tgl = ~r_reg.rb_tgl;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r_reg <= '0;
            r_reg.cfg <= ADCFG_CFG_RESET;
            r_reg.state <= ADCFG_IDLE;
            r_reg.gain_eff <= ADCFG_CFG_RESET[ADCFG_GAIN_LSB +: 3];
            r_reg.rb_word <= ADCFG_CFG_RESET;
            r_reg.alert_pin <= 1'b1;
            r_reg.alert_oe_n <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign conv_start = r_reg.conv_start;
    assign input_select = r_reg.cfg[ADCFG_MUX_LSB +: 3];
    assign gain_range_select = r_reg.gain_eff;
    assign sample_rate_select = r_reg.cfg[ADCFG_RATE_LSB +: 3];
    assign cont_mode = ~r_reg.cfg[ADCFG_MODE_BIT];
    assign alert_out = r_reg.alert_pin;
    assign alert_oe_n = r_reg.alert_oe_n;
    assign lnk_rd_data = l_reg.rd_data;
    assign lnk_alert_pending = l_reg.alert_pending;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence trig_write_s;
        r_reg.state == ADCFG_IDLE && r_reg.cfg[ADCFG_MODE_BIT]
            && wr_evt && l_reg.wr_word[ADCFG_TRIG_BIT];
    endsequence

    sequence start_busy_s;
        r_reg.conv_start && r_reg.state == ADCFG_BUSY;
    endsequence

    sequence trip_one_s;
        comp_en && conv_done && r_reg.state == ADCFG_BUSY && trip
            && r_reg.cfg[ADCFG_QUE_LSB +: 2] == ADCFG_QUE_ONE;
    endsequence

    trig_start_a: assert property (@(posedge clk) disable iff (sys_rst)
        trig_write_s |=> start_busy_s ##1 !r_reg.conv_start)
        else $error("trigger write did not start one conversion");

    busy_ignore_a: assert property (@(posedge clk) disable iff (sys_rst)
        r_reg.state == ADCFG_BUSY && !conv_done |=> !r_reg.conv_start)
        else $error("conversion started while busy");

    trig_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        r_reg.rb_tgl != $past(r_reg.rb_tgl)
        |-> r_reg.rb_word[ADCFG_TRIG_BIT] == (r_reg.state == ADCFG_IDLE))
        else $error("trigger readback disagrees with busy state");

    cfg_reset_a: assert property (@(posedge clk)
        sys_rst |=> r_reg.cfg == ADCFG_CFG_RESET && alert_oe_n)
        else $error("configuration reset value wrong");

    gain_map_a: assert property (@(posedge clk) disable iff (sys_rst)
        r_reg.cfg[ADCFG_GAIN_LSB +: 3] == ADCFG_GAIN_UNDOC |-> gain_range_select == ADCFG_GAIN_MIN)
        else $error("undocumented gain not mapped");

    queue_off_a: assert property (@(posedge clk) disable iff (sys_rst)
        !comp_en |-> alert_oe_n ##1 !r_reg.alert_act)
        else $error("disabled comparator still drives flag");

    trip_one_a: assert property (@(posedge clk) disable iff (sys_rst)
        trip_one_s |=> r_reg.alert_act)
        else $error("single trip did not assert flag");

    latch_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        comp_en && r_reg.alert_act && r_reg.cfg[ADCFG_LAT_BIT] && !clr_evt
        && $stable(r_reg.cfg) |=> r_reg.alert_act)
        else $error("latched flag dropped without clear");

    release_a: assert property (@(posedge clk) disable iff (sys_rst)
        comp_en && conv_done && r_reg.state == ADCFG_BUSY && !trip
        && !r_reg.cfg[ADCFG_LAT_BIT] && !r_reg.cfg[ADCFG_CMODE_BIT] && below_lo
        |=> !r_reg.alert_act)
        else $error("non-latched flag did not release");

    polarity_a: assert property (@(posedge clk) disable iff (sys_rst)
        comp_en && !rdy_mode && $stable(r_reg.cfg) && $stable(r_reg.alert_act)
        |-> alert_out == (r_reg.cfg[ADCFG_POL_BIT] ? r_reg.alert_act : ~r_reg.alert_act))
        else $error("flag polarity wrong");

    rd_msb_a: assert property (@(posedge link_clk) disable iff (link_rst)
        lnk_rd_req && lnk_rd_msb && lnk_rd_ptr == ADCFG_PTR_CONFIG
        |=> lnk_rd_data == $past(l_reg.rb_copy[15:8]))
        else $error("read did not return high byte first");

    rd_lsb_a: assert property (@(posedge link_clk) disable iff (link_rst)
        lnk_rd_req && !lnk_rd_msb && lnk_rd_ptr == ADCFG_PTR_CONFIG
        |=> lnk_rd_data == $past(l_reg.rb_copy[7:0]))
        else $error("read did not return low byte second");

    rd_other_a: assert property (@(posedge link_clk) disable iff (link_rst)
        lnk_rd_req && lnk_rd_ptr != ADCFG_PTR_CONFIG |=> lnk_rd_data == 8'h00)
        else $error("other pointer read not zero");

    nolatch_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
        comp_en && r_reg.alert_act && !r_reg.cfg[ADCFG_LAT_BIT] && !conv_done
        |=> r_reg.alert_act)
        else $error("non-latched flag dropped without a result");

    rdy_mirror_a: assert property (@(posedge clk) disable iff (sys_rst)
        !$past(sys_rst) && $past(rdy_mode) && r_reg.cfg[ADCFG_MODE_BIT]
        |-> alert_out == (r_reg.cfg[ADCFG_POL_BIT] ~^ (r_reg.state == ADCFG_IDLE)))
        else $error("ready flag does not mirror trigger status");

    rdy_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
        !$past(sys_rst) && $past(rdy_mode) && !r_reg.cfg[ADCFG_MODE_BIT]
        |-> alert_out == (r_reg.cfg[ADCFG_POL_BIT] ~^ r_reg.rdy_pulse))
        else $error("ready pulse missing in continuous mode");

endmodule : adcfg_ctrl

// [hdl/adcfg_pkg.sv]
package adcfg_pkg;

    // ------------------------------------------------------------
    // register map and layout
    // ------------------------------------------------------------
    localparam logic [1:0] ADCFG_PTR_CONFIG = 2'h1;
    localparam logic [15:0] ADCFG_CFG_RESET = 16'h8583;
    localparam int ADCFG_TRIG_BIT = 15;
    localparam int ADCFG_MUX_LSB = 12;
    localparam int ADCFG_GAIN_LSB = 9;
    localparam int ADCFG_MODE_BIT = 8;
    localparam int ADCFG_RATE_LSB = 5;
    localparam int ADCFG_CMODE_BIT = 4;
    localparam int ADCFG_POL_BIT = 3;
    localparam int ADCFG_LAT_BIT = 2;
    localparam int ADCFG_QUE_LSB = 0;
    localparam int ADCFG_THR_MSB = 15;
    localparam logic [1:0] ADCFG_QUE_OFF = 2'h3;
    localparam logic [1:0] ADCFG_QUE_ONE = 2'h0;
    localparam logic [1:0] ADCFG_QUE_TWO = 2'h1;
    localparam logic [2:0] ADCFG_NEED_1 = 3'h1;
    localparam logic [2:0] ADCFG_NEED_2 = 3'h2;
    localparam logic [2:0] ADCFG_NEED_4 = 3'h4;
    localparam logic [2:0] ADCFG_GAIN_MIN = 3'h6;
    localparam logic [2:0] ADCFG_GAIN_UNDOC = 3'h7;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ADCFG_IDLE = 2'b01,
        ADCFG_BUSY = 2'b10
    } adcfg_state_t;

    typedef struct packed {
        logic [15:0] cfg;
        adcfg_state_t state;
        logic conv_start;
        logic [2:0] gain_eff;
        logic [2:0] wr_sync;
        logic [2:0] rd_sync;
        logic [2:0] ara_sync;
        logic [1:0] ack_sync;
        logic rb_tgl;
        logic [15:0] rb_word;
        logic [2:0] run_cnt;
        logic alert_act;
        logic rdy_pulse;
        logic alert_pin;
        logic alert_oe_n;
    } adcfg_core_t;

    typedef struct packed {
        logic [7:0] msb_hold;
        logic have_msb;
        logic [15:0] wr_word;
        logic wr_tgl;
        logic rd_tgl;
        logic ara_tgl;
        logic [2:0] rb_sync;
        logic [15:0] rb_copy;
        logic ack_tgl;
        logic [1:0] alert_sync;
        logic [7:0] rd_data;
        logic alert_pending;
    } adcfg_link_t;

    typedef struct packed {
        logic valid;
        logic msb;
        logic [1:0] ptr;
        logic [7:0] data;
    } adcfg_byte_t;

endpackage : adcfg_pkg

// [test/adcfg_ctrl_tb.sv]
module adcfg_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import adcfg_pkg::*;

    localparam logic [15:0] res_hi = 16'h01f4;
    localparam logic [15:0] res_lo = 16'hfe0c;
    localparam logic [15:0] res_in = 16'h0000;

    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic sys_rst = 1'b1;
    adcfg_byte_t lnk_wr;
    logic lnk_rd_req, lnk_rd_msb, lnk_conv_read, lnk_alert_resp, lnk_alert_pending;
    logic [1:0] lnk_rd_ptr;
    logic [7:0] lnk_rd_data;
    logic conv_done = 1'b0;
    logic [15:0] conv_result = 16'h0000;
    logic [15:0] lo_thresh = 16'hff9c;
    logic [15:0] hi_thresh = 16'h0064;
    logic conv_start, cont_mode, alert_out, alert_oe_n;
    logic [2:0] input_select, gain_range_select, sample_rate_select;
    logic [15:0] rd, w;
    int n_errors = 0;
    int num_checks = 0;
    int n_starts = 0;
    int conv_cnt = 0;
    int conv_lat = 60;
    int old;

    always #2.5 clk = ~clk;
    always #3 link_clk = ~link_clk;

    adcfg_ctrl uut (.clk(clk), .sys_rst(sys_rst), .link_clk(link_clk), .lnk_wr(lnk_wr),
        .lnk_rd_req(lnk_rd_req), .lnk_rd_msb(lnk_rd_msb), .lnk_rd_ptr(lnk_rd_ptr),
        .lnk_conv_read(lnk_conv_read), .lnk_alert_resp(lnk_alert_resp),
        .lnk_rd_data(lnk_rd_data), .lnk_alert_pending(lnk_alert_pending),
        .conv_done(conv_done), .conv_result(conv_result), .lo_thresh(lo_thresh),
        .hi_thresh(hi_thresh), .conv_start(conv_start), .input_select(input_select),
        .gain_range_select(gain_range_select), .sample_rate_select(sample_rate_select),
        .cont_mode(cont_mode), .alert_out(alert_out), .alert_oe_n(alert_oe_n));

    adcfg_host_model host (.link_clk(link_clk), .lnk_wr(lnk_wr), .lnk_rd_req(lnk_rd_req),
        .lnk_rd_msb(lnk_rd_msb), .lnk_rd_ptr(lnk_rd_ptr), .lnk_conv_read(lnk_conv_read),
        .lnk_alert_resp(lnk_alert_resp), .lnk_rd_data(lnk_rd_data));

    // converter: one done pulse conv_lat cycles after each start
    always @(posedge clk) begin
        #1;
        conv_done = (conv_cnt == 1);
        if (conv_cnt != 0) conv_cnt = conv_cnt - 1;
        if (conv_start === 1'b1) begin
            n_starts = n_starts + 1;
            conv_cnt = conv_lat;
        end
    end

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    // one triggered conversion, then an optional clear, then the pin value
    task automatic step(input logic [7:0] low, input logic [15:0] res, input int act,
                        input logic exp);
        @(posedge clk);
        #1;
        conv_result = res;
        host.wr_word(ADCFG_PTR_CONFIG, {8'h85, low});
        chk(16'(alert_oe_n), 16'h0);
        if (act != 0) begin
            chk(16'(lnk_alert_pending), 16'h1);
            host.pulse(act == 2);
            chk(16'(lnk_alert_pending), 16'h0);
        end
        chk(16'(alert_out), 16'(exp));
    endtask : step

    initial begin
        repeat (40000) @(posedge clk);
        n_errors++;
        stop_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        repeat (4) @(posedge link_clk);
        host.rd_word(ADCFG_PTR_CONFIG, rd);
        chk(rd, ADCFG_CFG_RESET);
        chk(16'(input_select), 16'h0);
        chk(16'(gain_range_select), 16'h2);
        chk(16'(sample_rate_select), 16'h4);
        chk(16'(cont_mode), 16'h0);
        chk(16'(alert_oe_n), 16'h1);
        host.rd_word(2'h2, rd);
        chk(rd, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            w = {1'b0, 3'(i), 3'(i), 1'b1, 3'(i), 5'h03};
            host.wr_word(ADCFG_PTR_CONFIG, w);
            chk(16'(input_select), 16'(i));
            chk(16'(gain_range_select), (i == 7) ? 16'(ADCFG_GAIN_MIN) : 16'(i));
            chk(16'(sample_rate_select), 16'(i));
            host.rd_word(ADCFG_PTR_CONFIG, rd);
            chk(rd, w | 16'h8000);
        end
        chk(16'(n_starts), 16'h0);
        host.wr_word(2'h0, 16'h0000);
        chk(16'(sample_rate_select), 16'h7);
        host.wr_word(ADCFG_PTR_CONFIG, 16'h8583);
        chk(16'(n_starts), 16'h1);
        host.rd_word(ADCFG_PTR_CONFIG, rd);
        chk(16'(rd[15]), 16'h0);
        host.wr_word(ADCFG_PTR_CONFIG, 16'h8583);
        repeat (50) @(posedge link_clk);
        chk(16'(n_starts), 16'h1);
        host.rd_word(ADCFG_PTR_CONFIG, rd);
        chk(16'(rd[15]), 16'h1);
        conv_lat = 4;
        old = n_starts;
        host.wr_word(ADCFG_PTR_CONFIG, 16'h0483);
        chk(16'(cont_mode), 16'h1);
        chk(16'(n_starts - old > 2), 16'h1);
        host.wr_word(ADCFG_PTR_CONFIG, 16'h0583);
        step(8'h81, res_in, 0, 1'b1);
        step(8'h81, res_hi, 0, 1'b1);
        step(8'h81, res_hi, 0, 1'b0);
        step(8'h81, res_in, 0, 1'b0);
        step(8'h81, res_lo, 0, 1'b1);
        step(8'h82, res_in, 0, 1'b1);
        for (int i = 0; i < 3; i++) begin
            step(8'h82, res_hi, 0, 1'b1);
        end
        step(8'h82, res_hi, 0, 1'b0);
        step(8'h82, res_lo, 0, 1'b1);
        step(8'h88, res_in, 0, 1'b0);
        step(8'h88, res_hi, 0, 1'b1);
        step(8'h88, res_lo, 0, 1'b0);
        step(8'h90, res_in, 0, 1'b1);
        step(8'h90, res_lo, 0, 1'b0);
        step(8'h90, res_in, 0, 1'b1);
        step(8'h90, res_hi, 0, 1'b0);
        step(8'h90, res_in, 0, 1'b1);
        step(8'h84, res_in, 0, 1'b1);
        step(8'h84, res_hi, 0, 1'b0);
        step(8'h84, res_lo, 0, 1'b0);
        step(8'h84, res_lo, 1, 1'b1);
        step(8'h84, res_hi, 2, 1'b1);
        // ready mode: high threshold sign set, low threshold sign clear
        @(posedge clk);
        #1;
        hi_thresh = 16'h8000;
        lo_thresh = 16'h0000;
        old = n_starts;
        host.wr_word(ADCFG_PTR_CONFIG, 16'h0488);
        chk(16'(n_starts - old > 2), 16'h1);
        step(8'h80, res_in, 0, 1'b0);
        step(8'h88, res_in, 0, 1'b1);
        host.wr_word(ADCFG_PTR_CONFIG, 16'h8583);
        chk(16'(alert_oe_n), 16'h1);
        stop_test();
    end
endmodule : adcfg_ctrl_tb

// [test/adcfg_host_model.sv]
module adcfg_host_model (
    input wire logic link_clk,
    output adcfg_pkg::adcfg_byte_t lnk_wr,
    output logic lnk_rd_req,
    output logic lnk_rd_msb,
    output logic [1:0] lnk_rd_ptr,
    output logic lnk_conv_read,
    output logic lnk_alert_resp,
    input wire logic [7:0] lnk_rd_data
);
    timeunit 1ns;
    timeprecision 100ps;
    import adcfg_pkg::*;

    initial begin
        lnk_wr = '0;
        lnk_rd_req = 1'b0;
        lnk_rd_msb = 1'b0;
        lnk_rd_ptr = 2'h0;
        lnk_conv_read = 1'b0;
        lnk_alert_resp = 1'b0;
    end

    task automatic tick;
        @(posedge link_clk);
        #1;
    endtask : tick

    // high byte then low byte; released byte lines show the inverse
    task automatic wr_word(input logic [1:0] ptr, input logic [15:0] w);
        tick();
        lnk_wr = '{valid: 1'b1, msb: 1'b1, ptr: ptr, data: w[15:8]};
        tick();
        lnk_wr = '{valid: 1'b1, msb: 1'b0, ptr: ptr, data: w[7:0]};
        tick();
        lnk_wr = '{valid: 1'b0, msb: 1'b0, ptr: ~ptr, data: ~w[7:0]};
        repeat (16) tick();
    endtask : wr_word

    task automatic rd_byte(input logic [1:0] ptr, input logic first, output logic [7:0] b);
        tick();
        lnk_rd_req = 1'b1;
        lnk_rd_msb = first;
        lnk_rd_ptr = ptr;
        tick();
        lnk_rd_req = 1'b0;
        lnk_rd_msb = ~first;
        lnk_rd_ptr = ~ptr;
        tick();
        b = lnk_rd_data;
    endtask : rd_byte

    task automatic rd_word(input logic [1:0] ptr, output logic [15:0] w);
        rd_byte(ptr, 1'b1, w[15:8]);
        rd_byte(ptr, 1'b0, w[7:0]);
    endtask : rd_word

    // result read when resp is 0, alert response when resp is 1
    task automatic pulse(input logic resp);
        tick();
        lnk_alert_resp = resp;
        lnk_conv_read = ~resp;
        tick();
        lnk_alert_resp = 1'b0;
        lnk_conv_read = 1'b0;
        repeat (16) tick();
    endtask : pulse
endmodule : adcfg_host_model
